// *** verilog/hss_pkg.sv ***
package hss_pkg;

   // number of high-side outputs and configuration field width
   localparam int NUM_OUT   = 4;
   localparam int CFG_W     = 3;

   // register word addresses (compared directly with the 4-bit avalon-mm address)
   localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
   localparam logic [3:0] ADDR_SUP_CFG  = 4'h2;
   localparam logic [3:0] ADDR_OC_STAT  = 4'h3;
   localparam logic [3:0] ADDR_OL_STAT  = 4'h4;
   localparam logic [3:0] ADDR_SUP_STAT = 4'h5;
   localparam logic [3:0] ADDR_OUT_STAT = 4'h6;

   // field positions inside the supply configuration register
   localparam int SUP_OV_DIS_BIT = 0;
   localparam int SUP_UV_DIS_BIT = 1;
   localparam int SUP_REC_BIT    = 2;

   // field positions inside the supply status register
   localparam int STAT_OV_BIT = 0;
   localparam int STAT_UV_BIT = 1;

   // configuration codes of one output
   localparam logic [2:0] CFG_OFF  = 3'h0;
   localparam logic [2:0] CFG_ON   = 3'h1;
   localparam logic [2:0] CFG_TMR1 = 3'h2;
   localparam logic [2:0] CFG_TMR2 = 3'h3;
   localparam logic [2:0] CFG_PWM1 = 3'h4;
   localparam logic [2:0] CFG_PWM2 = 3'h5;

   // reset values
   localparam logic [2:0] CFG_RST   = 3'h0;
   localparam logic [2:0] SUP_RST   = 3'h0;

   // timing: clock rate and filter times
   localparam int CLK_HZ        = 10_000_000;
   localparam int OC_FILT_US    = 16;
   localparam int OL_FILT_US    = 64;
   localparam int OC_FILT_CYC   = (OC_FILT_US * (CLK_HZ / 1_000_000));
   localparam int OL_FILT_CYC   = (OL_FILT_US * (CLK_HZ / 1_000_000));
   localparam int FILT_W        = 10;

   // chip operating modes as seen by this block
   typedef enum logic [2:0]
   {
      HSS_MODE_NORMAL   = 3'b000,
      HSS_MODE_STOP     = 3'b001,
      HSS_MODE_SLEEP    = 3'b010,
      HSS_MODE_RESTART  = 3'b011,
      HSS_MODE_FAILSAFE = 3'b100,
      HSS_MODE_INIT     = 3'b101
   } hss_mode_t;

   // per-output analog sense results
   typedef struct packed
   {
      logic over_current;
      logic open_load;
   } hss_sense_t;

   // avalon-mm request
   typedef struct packed
   {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } hss_av_req_t;

endpackage

// *** verilog/hss_switch_ctrl.sv ***
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// What this block does
// - low-power modes keep configuration, ignore configuration writes
// - restart or fail-safe switches all outputs off
// - each output driven directly, by timer, or PWM
// - supply overvoltage cuts outputs unless disabled
// - overvoltage end with recovery restores outputs
// - supply undervoltage cuts outputs unless disabled
// - undervoltage end with recovery restores outputs
// - outputs return to programmed state only if recovery
// - without recovery, cut outputs stay off, config cleared
// - supply faults only set two supply flags
// - sustained overcurrent beyond filter time turns output off
// - overcurrent shutdown sets output's overcurrent flag
// - overcurrent shutdown resets config field to off
// - overcurrent flags cleared only by software
// - open load while on sets open-load flag
// - open load leaves the output on
// - open-load flags held until software clears
// - after restart or fail-safe, software may re-enable
// - PWM drive starts as soon as assigned
module hss_switch_ctrl
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // avalon-mm slave
   input  wire hss_pkg::hss_av_req_t av_req,
   output logic [31:0]               av_readdata,
   output logic                      av_waitrequest,
   // chip mode and supply monitors
   input  wire hss_pkg::hss_mode_t   chip_mode,
   input  wire logic                 supply_ov,
   input  wire logic                 supply_uv,
   // drive sources from timers and pwm generators
   input  wire logic [1:0]           timer_out,
   input  wire logic [1:0]           pwm_out,
   // per-output current sense
   input  wire hss_pkg::hss_sense_t [3:0] sense,
   // switch gate drive
   output logic [3:0]                high_side_output
);

   // register state
   logic [3:0][2:0] cfg_reg, cfg_next;
   logic [2:0]      sup_cfg_reg, sup_cfg_next;
   logic [3:0]      oc_flag_reg, oc_flag_next;
   logic [3:0]      ol_flag_reg, ol_flag_next;
   logic            ov_flag_reg, ov_flag_next;
   logic            uv_flag_reg, uv_flag_next;
   logic [3:0]      out_reg, out_next;
   logic [31:0]     rdata_reg, rdata_next;
   logic            ack_reg, ack_next;
   logic            wait_reg;
   logic [3:0][9:0] oc_cnt_reg, oc_cnt_next;
   logic [3:0][9:0] ol_cnt_reg, ol_cnt_next;

   // combinational helpers
   logic            normal_mode;
   logic            kill_mode;
   logic            ov_cut, uv_cut, sup_cut, sup_cut_q;
   logic            sup_end_norec;
   logic            acc_wr, acc_rd;
   logic [3:0]      src_level;
   logic [3:0]      oc_trip;
   logic [3:0]      ol_trip;

   // waitrequest drops for one cycle after a request is seen; own flop
   // so the bus sees no gate between register and pin
   assign av_waitrequest = wait_reg;
   assign av_readdata    = rdata_reg;
   assign high_side_output = out_reg;
   assign acc_wr = av_req.write & ~ack_reg;
   assign acc_rd = av_req.read & ~ack_reg;

   // mode decode
   assign normal_mode = (chip_mode == hss_pkg::HSS_MODE_NORMAL);
   assign kill_mode   = (chip_mode == hss_pkg::HSS_MODE_RESTART) |
                        (chip_mode == hss_pkg::HSS_MODE_FAILSAFE);

   // supply cut-off decisions
   assign ov_cut  = supply_ov & ~sup_cfg_reg[hss_pkg::SUP_OV_DIS_BIT];
   assign uv_cut  = supply_uv & ~sup_cfg_reg[hss_pkg::SUP_UV_DIS_BIT];
   assign sup_cut = ov_cut | uv_cut;
   // remembered as the previous-cycle view of the supply cut
   assign sup_end_norec = sup_cut_q & ~sup_cut &
                          ~sup_cfg_reg[hss_pkg::SUP_REC_BIT];

   // per-output source select and filter terminals
   genvar g;
   generate
      for (g = 0; g < hss_pkg::NUM_OUT; g++)
      begin : g_out
         always_comb
         begin
            unique case (cfg_reg[g])
               hss_pkg::CFG_ON:   src_level[g] = 1'b1;
               hss_pkg::CFG_TMR1: src_level[g] = timer_out[0];
               hss_pkg::CFG_TMR2: src_level[g] = timer_out[1];
               hss_pkg::CFG_PWM1: src_level[g] = pwm_out[0];
               hss_pkg::CFG_PWM2: src_level[g] = pwm_out[1];
               default:           src_level[g] = 1'b0;
            endcase
         end
         assign oc_trip[g] = out_reg[g] & sense[g].over_current &
            (oc_cnt_reg[g] == 10'(hss_pkg::OC_FILT_CYC - 1));
         assign ol_trip[g] = out_reg[g] & sense[g].open_load &
            (ol_cnt_reg[g] == 10'(hss_pkg::OL_FILT_CYC - 1));
      end
   endgenerate

   // next state of configuration, flags, outputs and bus answer
   always_comb
   begin
      cfg_next     = cfg_reg;
      sup_cfg_next = sup_cfg_reg;
      oc_flag_next = oc_flag_reg;
      ol_flag_next = ol_flag_reg;
      ov_flag_next = supply_ov;
      uv_flag_next = supply_uv;
      rdata_next   = rdata_reg;
      ack_next     = 1'b0;
      oc_cnt_next  = oc_cnt_reg;
      ol_cnt_next  = ol_cnt_reg;

      // software writes: config only in normal mode, clears are write-1
      if (acc_wr)
      begin
         ack_next = 1'b1;
         unique case (av_req.address)
            hss_pkg::ADDR_CTRL_A:
               if (normal_mode | kill_mode)
               begin
                  cfg_next[0] = av_req.writedata[2:0];
                  cfg_next[1] = av_req.writedata[6:4];
               end
            hss_pkg::ADDR_CTRL_B:
               if (normal_mode | kill_mode)
               begin
                  cfg_next[2] = av_req.writedata[2:0];
                  cfg_next[3] = av_req.writedata[6:4];
               end
            hss_pkg::ADDR_SUP_CFG:
               if (normal_mode)
                  sup_cfg_next = av_req.writedata[2:0];
            hss_pkg::ADDR_OC_STAT:
               oc_flag_next = oc_flag_reg & ~av_req.writedata[3:0];
            hss_pkg::ADDR_OL_STAT:
               ol_flag_next = ol_flag_reg & ~av_req.writedata[3:0];
            default: ;
         endcase
      end
      else if (acc_rd)
      begin
         ack_next   = 1'b1;
         rdata_next = 32'h0;
         unique case (av_req.address)
            hss_pkg::ADDR_CTRL_A:
               rdata_next[6:0] = {cfg_reg[1], 1'b0, cfg_reg[0]};
            hss_pkg::ADDR_CTRL_B:
               rdata_next[6:0] = {cfg_reg[3], 1'b0, cfg_reg[2]};
            hss_pkg::ADDR_SUP_CFG:  rdata_next[2:0] = sup_cfg_reg;
            hss_pkg::ADDR_OC_STAT:  rdata_next[3:0] = oc_flag_reg;
            hss_pkg::ADDR_OL_STAT:  rdata_next[3:0] = ol_flag_reg;
            hss_pkg::ADDR_SUP_STAT:
               rdata_next[1:0] = {uv_flag_reg, ov_flag_reg};
            hss_pkg::ADDR_OUT_STAT: rdata_next[3:0] = out_reg;
            default:                rdata_next = 32'h0;
         endcase
      end

      // supply fault ended without recovery: control bits cleared
      if (sup_end_norec)
         cfg_next = '0;

      // filters, overcurrent shutdown and open-load flags per output
      for (int i = 0; i < hss_pkg::NUM_OUT; i++)
      begin
         if (out_reg[i] & sense[i].over_current & ~oc_trip[i])
            oc_cnt_next[i] = oc_cnt_reg[i] + 10'h001;
         else
            oc_cnt_next[i] = 10'h000;
         if (out_reg[i] & sense[i].open_load & ~ol_trip[i])
            ol_cnt_next[i] = ol_cnt_reg[i] + 10'h001;
         else
            ol_cnt_next[i] = 10'h000;
         if (oc_trip[i])
         begin
            cfg_next[i]     = hss_pkg::CFG_OFF;
            oc_flag_next[i] = 1'b1;
         end
         if (ol_trip[i])
            ol_flag_next[i] = 1'b1;
      end

      // output drive: cut by mode, supply fault or same-cycle trip; the
      // fault-end cycle without recovery is cut too, else the old config
      // would pulse the switch on for one cycle before it is cleared
      for (int i = 0; i < hss_pkg::NUM_OUT; i++)
      begin
         out_next[i] = src_level[i] & ~kill_mode & ~sup_cut
                       & ~sup_end_norec
                       & ~oc_trip[i];
      end
      if (kill_mode)
         cfg_next = '0;
   end

   // registers
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cfg_reg     <= {4{hss_pkg::CFG_RST}};
         sup_cfg_reg <= hss_pkg::SUP_RST;
         oc_flag_reg <= 4'h0;
         ol_flag_reg <= 4'h0;
         ov_flag_reg <= 1'b0;
         uv_flag_reg <= 1'b0;
         out_reg     <= 4'h0;
         rdata_reg   <= 32'h0;
         ack_reg     <= 1'b0;
         wait_reg    <= 1'b1;
         oc_cnt_reg  <= '0;
         ol_cnt_reg  <= '0;
         sup_cut_q   <= 1'b0;
      end
      else
      begin
         cfg_reg     <= cfg_next;
         sup_cfg_reg <= sup_cfg_next;
         oc_flag_reg <= oc_flag_next;
         ol_flag_reg <= ol_flag_next;
         ov_flag_reg <= ov_flag_next;
         uv_flag_reg <= uv_flag_next;
         out_reg     <= out_next;
         rdata_reg   <= rdata_next;
         ack_reg     <= ack_next;
         wait_reg    <= ~ack_next;
         oc_cnt_reg  <= oc_cnt_next;
         ol_cnt_reg  <= ol_cnt_next;
         sup_cut_q   <= sup_cut;
      end
   end

endmodule

// *** sim/hss_load.sv ***
`timescale 1ns/100ps
module hss_load
(
   // switch drive and faults ordered by the bench
   input  wire logic [3:0]           high_side_output,
   input  wire logic [3:0]           oc_req,
   input  wire logic [3:0]           ol_req,
   // comparator results
   output hss_pkg::hss_sense_t [3:0] sense
);
   // an off switch carries no current, so open load reads high then
   always_comb
      for (int i = 0; i < 4; i++)
      begin
         sense[i].over_current = high_side_output[i] & oc_req[i];
         sense[i].open_load    = ~high_side_output[i] | ol_req[i];
      end
endmodule

// *** sim/hss_chk.sv ***
`timescale 1ns/100ps
module hss_chk
(
   // clock and reset
   input wire logic                      clock,
   input wire logic                      rst,
   // register bus, mode and supply
   input wire hss_pkg::hss_av_req_t      av_req,
   input wire logic [31:0]               av_readdata,
   input wire logic                      av_waitrequest,
   input wire hss_pkg::hss_mode_t        chip_mode,
   input wire logic                      supply_ov,
   input wire logic                      supply_uv,
   // loads and switches
   input wire hss_pkg::hss_sense_t [3:0] sense,
   input wire logic [3:0]                high_side_output
);
   logic [1:0] dis_reg;
   logic [7:0] run_reg;
   // cutoff disable bits; only normal mode writes count
   always_ff @(posedge clock or posedge rst)
      if (rst)
         dis_reg <= 2'h0;
      else if (av_req.write && av_waitrequest && av_req.address == 4'h2
               && chip_mode == hss_pkg::HSS_MODE_NORMAL)
         dis_reg <= av_req.writedata[1:0];
   // overcurrent run on output 0; cannot wrap as the trip ends it
   always_ff @(posedge clock or posedge rst)
      if (rst)
         run_reg <= 8'h0;
      else
         run_reg <= (high_side_output[0] && sense[0].over_current)
                    ? run_reg + 8'h1 : 8'h0;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wait_ans_a: assert property ((av_req.read || av_req.write)
      && av_waitrequest |=> !av_waitrequest) else $error("no answer");
   wait_one_a: assert property (!av_waitrequest |=> av_waitrequest)
      else $error("answer too long");
   rdata_hold_a: assert property (!(av_req.read && av_waitrequest)
      |=> $stable(av_readdata)) else $error("read data moved");
   mode_off_a: assert property (chip_mode inside {3'h3, 3'h4}
      |=> high_side_output == 4'h0) else $error("on in restart");
   ov_cut_a: assert property (supply_ov && !dis_reg[0]
      |=> high_side_output == 4'h0) else $error("on in overvoltage");
   uv_cut_a: assert property (supply_uv && !dis_reg[1]
      |=> high_side_output == 4'h0) else $error("on in undervoltage");
   oc_trip_a: assert property (run_reg == 8'hA0
      |-> !high_side_output[0]) else $error("no overcurrent trip");
   ol_keep_a: assert property (high_side_output[1] && sense[1].open_load
      && chip_mode == 3'h0 && !supply_ov && !supply_uv
      |=> high_side_output[1]) else $error("open load turned off");
   cover property (supply_ov && high_side_output != 4'h0);
   cover property (run_reg == 8'hA0);
   cover property (chip_mode == 3'h1 && high_side_output != 4'h0);
endmodule
bind hss_switch_ctrl hss_chk hss_chk_inst (.clock, .rst, .av_req,
   .av_readdata, .av_waitrequest, .chip_mode, .supply_ov, .supply_uv,
   .sense, .high_side_output);

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   logic                      clock = 1'b0;
   logic                      rst = 1'b1;
   hss_pkg::hss_av_req_t      av_req = '0;
   logic [31:0]               av_readdata;
   logic                      av_waitrequest;
   hss_pkg::hss_mode_t        chip_mode = hss_pkg::HSS_MODE_NORMAL;
   logic [1:0]                sup = 2'h0;
   logic [3:0]                src = 4'h0;
   hss_pkg::hss_sense_t [3:0] sense;
   logic [3:0]                hso;
   logic [3:0]                oc_req = 4'h0;
   logic [3:0]                ol_req = 4'h0;
   logic [31:0]               lf = 32'hA998;
   logic [31:0]               sc;
   logic [31:0]               exp_q[$];
   int                        err_count = 0;
   int                        cmp_count = 0;

   hss_switch_ctrl hss_switch_ctrl_inst (.clock, .rst, .av_req,
      .av_readdata, .av_waitrequest, .chip_mode, .supply_ov(sup[0]),
      .supply_uv(sup[1]), .timer_out(src[3:2]), .pwm_out(src[1:0]),
      .sense, .high_side_output(hso));
   hss_load hss_load_inst (.high_side_output(hso), .oc_req, .ol_req,
      .sense);

   // clock
   initial
      forever #50 clock = ~clock;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // random timer and pwm levels every cycle
   always @(posedge clock)
   begin
      lf <= lfsr(lf);
      src <= lf[3:0];
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask

   // one bus cycle; only the watchdog ends a hung wait
   task automatic av(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
      @(posedge clock);
      av_req <= '{read: !w, write: w, address: a, writedata: d};
      do
         @(posedge clock);
      while (av_waitrequest !== 1'b0);
      av_req <= '0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      av(1'b0, a, 32'h0);
   endtask

   // read data are compared at the edge that ends the read
   always @(posedge clock)
      if (av_req.read && av_waitrequest === 1'b0)
         chk(av_readdata, exp_q.pop_front());

   // outputs follow {timer2, timer1, pwm2, pwm1} one cycle late
   task automatic src_chk();
      logic [3:0] e;
      @(posedge clock);
      e = src;
      repeat (16)
      begin
         @(posedge clock);
         chk({28'h0, hso}, {28'h0, e});
         e = src;
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog, well above the roughly 1300 cycles the run needs
   initial
   begin
      repeat (20000) @(posedge clock);
      err_count++;
      give_verdict();
   end

   // main sequence
   initial
   begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++)
         rd(4'(a), 32'h0);
      av(1'b1, 4'h0, 32'h54);
      av(1'b1, 4'h1, 32'h32);
      src_chk();
      for (int m = 1; m < 3; m++)
      begin
         chip_mode <= hss_pkg::hss_mode_t'(m[2:0]);
         av(1'b1, 4'h0, 32'h0);
         rd(4'h0, 32'h54);
         src_chk();
      end
      for (int m = 3; m < 5; m++)
      begin
         chip_mode <= hss_pkg::HSS_MODE_NORMAL;
         av(1'b1, 4'h0, 32'h11);
         chip_mode <= hss_pkg::hss_mode_t'(m[2:0]);
         rd(4'h6, 32'h0);
         rd(4'h0, 32'h0);
      end
      chip_mode <= hss_pkg::HSS_MODE_NORMAL;
      av(1'b1, 4'h0, 32'h11);
      av(1'b1, 4'h1, 32'h0);
      rd(4'h6, 32'h3);
      // recovery, no recovery, cutoff disabled; overvoltage then under
      for (int i = 0; i < 2; i++)
         for (int c = 0; c < 3; c++)
         begin
            sc = (c == 1) ? 32'h0 : 32'h4 | ((c == 2) ? 32'h1 << i : 32'h0);
            av(1'b1, 4'h2, sc);
            av(1'b1, 4'h0, 32'h11);
            sup <= 2'h1 << i;
            rd(4'h5, 32'h1 << i);
            rd(4'h6, (c == 2) ? 32'h3 : 32'h0);
            rd(4'h3, 32'h0);
            sup <= 2'h0;
            rd(4'h6, (c == 1) ? 32'h0 : 32'h3);
            rd(4'h0, (c == 1) ? 32'h0 : 32'h11);
         end
      oc_req <= 4'h1;
      repeat (150) @(posedge clock);
      oc_req <= 4'h0;
      rd(4'h6, 32'h3);
      oc_req <= 4'h1;
      repeat (170) @(posedge clock);
      oc_req <= 4'h0;
      rd(4'h6, 32'h2);
      rd(4'h3, 32'h1);
      rd(4'h0, 32'h10);
      av(1'b1, 4'h3, 32'h1);
      rd(4'h3, 32'h0);
      av(1'b1, 4'h0, 32'h11);
      rd(4'h6, 32'h3);
      ol_req <= 4'h2;
      repeat (660) @(posedge clock);
      rd(4'h6, 32'h3);
      rd(4'h4, 32'h2);
      ol_req <= 4'h0;
      rd(4'h4, 32'h2);
      av(1'b1, 4'h4, 32'h2);
      rd(4'h4, 32'h0);
      give_verdict();
   end
endmodule
